// [hw/sadc_defines.vh]
// Purpose: shared constants of the serial sar readout sequencer
// Assumes: included by bare name from the design file
// Notes:   edge counts are falling conversion clock edges after select low
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ==========================================================================
// result format
// ==========================================================================
`define SADC_RES_W 12
`define SADC_IN_W 24
`define SADC_CODE_ZERO 12'h000
`define SADC_CODE_MID 12'h800
`define SADC_CODE_FULL 12'hFFF

// ==========================================================================
// sequence edge numbers
// ==========================================================================
`define SADC_CNT_W 5
`define SADC_EDGE_HOLD 5'h02
`define SADC_EDGE_MSB 5'h03
`define SADC_EDGE_LSB 5'h0E
`define SADC_EDGE_REV_LAST 5'h19

// ==========================================================================
// input buffer
// ==========================================================================
`define SADC_FIFO_DEPTH 16
`define SADC_FIFO_AW 4

// ==========================================================================
// pin synchroniser
// ==========================================================================
`define SADC_PIN_N 2
`define SADC_PIN_CS 0
`define SADC_PIN_CLK 1
// select idles high, clock idles low: no false edge after reset
`define SADC_PIN_RST 2'h1

`endif

// [hw/sadc_readout.v]
// Purpose: serial readout sequencer of a 12-bit sar converter
// Assumes: select and conversion clock are asynchronous pins
// Notes:   analog front end appears as a stream of digitised pos/neg words
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defines.vh"

// ==========================================================================
// input word buffer
// ==========================================================================
module sadc_fifo #(
    parameter WIDTH = `SADC_IN_W,
    parameter DEPTH = `SADC_FIFO_DEPTH,
    parameter AW = `SADC_FIFO_AW
) (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // fill side
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    reg [AW:0] nxt_count;
    wire push;
    wire pop;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_ff];
    always @*
    begin
        nxt_count = count_ff;
        if (push & ~pop)
            nxt_count = count_ff + {{AW{1'b0}}, 1'b1};
        else if (pop & ~push)
            nxt_count = count_ff - {{AW{1'b0}}, 1'b1};
    end
    always @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_ff] <= in_data;
    end
    // full and empty registered so both handshake outputs come from flops
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            count_ff <= nxt_count;
            in_ready <= (nxt_count != DEPTH[AW:0]);
            out_valid <= (nxt_count != {(AW+1){1'b0}});
        end
    end
endmodule // sadc_fifo

// ==========================================================================
// readout sequencer
// ==========================================================================
module sadc_readout (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // serial pins
    input wire cs_n,
    input wire conversion_shift_clock,
    output reg sdo_out,
    output reg sdo_oe,
    // digitised input stream, pos code in high half
    input wire ain_valid,
    output wire ain_ready,
    input wire [`SADC_IN_W-1:0] ain_data,
    // status
    output reg sample_active,
    output reg analog_pd,
    output reg digital_pd,
    output reg result_underrun
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_SAMPLE = 6'h02;
    localparam [5:0] ST_NULL = 6'h04;
    localparam [5:0] ST_MSBF = 6'h08;
    localparam [5:0] ST_LSBF = 6'h10;
    localparam [5:0] ST_DONE = 6'h20;
    localparam [`SADC_PIN_N-1:0] PIN_RST = `SADC_PIN_RST;
    reg [5:0] state_ff;
    reg [`SADC_CNT_W-1:0] edge_cnt_ff;
    reg [`SADC_RES_W-1:0] result_ff;
    reg [`SADC_PIN_N-1:0] pin_meta_ff;
    reg [`SADC_PIN_N-1:0] pin_s2_ff;
    reg [`SADC_PIN_N-1:0] pin_s3_ff;
    reg [`SADC_PIN_N-1:0] pin_lvl_ff;
    wire [`SADC_PIN_N-1:0] pin_raw;
    wire [`SADC_PIN_N-1:0] pin_rise;
    wire [`SADC_PIN_N-1:0] pin_fall;
    wire [`SADC_CNT_W-1:0] edge_nxt;
    wire cs_fall;
    wire cs_high;
    wire clk_fall;
    wire capture;
    wire fifo_valid;
    wire [`SADC_IN_W-1:0] fifo_data;
    wire [`SADC_RES_W:0] diff;
    wire [`SADC_RES_W-1:0] code;
    // serial bit of a code by index
    function bit_at;
        input [`SADC_RES_W-1:0] c;
        input [`SADC_CNT_W-1:0] idx;
        begin
            bit_at = c[idx[3:0]];
        end
    endfunction
    // ======================================================================
    // pin synchronisers
    // ======================================================================
    assign pin_raw = {conversion_shift_clock, cs_n};
    genvar gi;
    generate
        for (gi = 0; gi < `SADC_PIN_N; gi = gi + 1)
        begin : g_pin
            // a change counts once stages two and three agree
            assign pin_rise[gi] = pin_s2_ff[gi] & pin_s3_ff[gi] &
                ~pin_lvl_ff[gi];
            assign pin_fall[gi] = ~pin_s2_ff[gi] & ~pin_s3_ff[gi] &
                pin_lvl_ff[gi];
            always @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    pin_meta_ff[gi] <= PIN_RST[gi];
                    pin_s2_ff[gi] <= PIN_RST[gi];
                    pin_s3_ff[gi] <= PIN_RST[gi];
                    pin_lvl_ff[gi] <= PIN_RST[gi];
                end
                else
                begin
                    pin_meta_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_meta_ff[gi];
                    pin_s3_ff[gi] <= pin_s2_ff[gi];
                    if (pin_s2_ff[gi] == pin_s3_ff[gi])
                        pin_lvl_ff[gi] <= pin_s3_ff[gi];
                end
            end
        end
    endgenerate
    assign cs_fall = pin_fall[`SADC_PIN_CS];
    // level as of this edge, so a counted fall is not taken for high
    assign cs_high = (pin_lvl_ff[`SADC_PIN_CS] & ~cs_fall) |
        pin_rise[`SADC_PIN_CS];
    assign clk_fall = pin_fall[`SADC_PIN_CLK];
    assign edge_nxt = edge_cnt_ff + 5'h01;
    // ======================================================================
    // hold capture
    // ======================================================================
    // single pop per cycle: the negative input is never revisited
    assign capture = (state_ff == ST_SAMPLE) & ~cs_high & clk_fall &
        (edge_nxt == `SADC_EDGE_HOLD);

    // straight binary, negative difference clips to zero
    assign diff = {1'b0, fifo_data[`SADC_IN_W-1:`SADC_RES_W]} -
        {1'b0, fifo_data[`SADC_RES_W-1:0]};
    assign code = diff[`SADC_RES_W] ? `SADC_CODE_ZERO :
        diff[`SADC_RES_W-1:0];

    sadc_fifo #(
        .WIDTH(`SADC_IN_W),
        .DEPTH(`SADC_FIFO_DEPTH),
        .AW(`SADC_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(ain_valid),
        .in_ready(ain_ready),
        .in_data(ain_data),
        .out_valid(fifo_valid),
        .out_ready(capture),
        .out_data(fifo_data)
    );

    // ======================================================================
    // sequencer
    // ======================================================================
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            edge_cnt_ff <= 5'h00;
            result_ff <= `SADC_CODE_ZERO;
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
            sample_active <= 1'b0;
            analog_pd <= 1'b1;
            digital_pd <= 1'b1;
            result_underrun <= 1'b0;
        end
        else if (cs_high)
        begin
            // abort at any point; output released within the sync delay
            state_ff <= ST_IDLE;
            sdo_oe <= 1'b0;
            sdo_out <= 1'b0;
            sample_active <= 1'b0;
            analog_pd <= 1'b1;
            digital_pd <= 1'b1;
        end
        else if (cs_fall)
        begin
            // a fall is only seen after select was high
            state_ff <= ST_SAMPLE;
            edge_cnt_ff <= 5'h00;
            sample_active <= 1'b1;
            analog_pd <= 1'b0;
            digital_pd <= 1'b0;
        end
        else if (clk_fall)
        begin
            case (state_ff)
                ST_SAMPLE:
                begin
                    edge_cnt_ff <= edge_nxt;
                    if (edge_nxt == `SADC_EDGE_HOLD)
                    begin
                        result_ff <= fifo_valid ? code : `SADC_CODE_ZERO;
                        result_underrun <= ~fifo_valid;
                        sample_active <= 1'b0;
                        sdo_oe <= 1'b1;
                        sdo_out <= 1'b0;
                        state_ff <= ST_NULL;
                    end
                end
                ST_NULL, ST_MSBF, ST_LSBF:
                begin
                    edge_cnt_ff <= edge_nxt;
                    if (edge_nxt <= `SADC_EDGE_LSB)
                    begin
                        // no pipeline: bits of this conversion
                        sdo_out <= bit_at(result_ff,
                            `SADC_EDGE_LSB - edge_nxt);
                        state_ff <= ST_MSBF;
                    end
                    else if (edge_nxt <= `SADC_EDGE_REV_LAST)
                    begin
                        sdo_out <= bit_at(result_ff,
                            edge_nxt - `SADC_EDGE_LSB);
                        state_ff <= ST_LSBF;
                    end
                    else
                    begin
                        sdo_oe <= 1'b0;
                        sdo_out <= 1'b0;
                        analog_pd <= 1'b1;
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE:
                    state_ff <= ST_DONE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // sadc_readout

`default_nettype wire

// [verif/sadc_host_model.sv]
// Purpose: host serial port driving select and conversion clock
// Assumes: each clock phase lasts six system clocks, select stays high at least twelve
// Notes: data captured at each rising conversion clock edge
`timescale 1ns/10ps
`default_nettype none
// ==========
// host model
module sadc_host_model (
    // clock
    input wire logic sys_clk,
    // data from the converter
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // select and clock to the converter
    output var logic cs_n,
    output var logic conversion_shift_clock
);
    logic cap_d [1:32];
    logic cap_e [1:32];
    initial
    begin
        cs_n = 1'h1;
        conversion_shift_clock = 1'h0;
    end
    // clock stands low outside frames; short n aborts the cycle
    task automatic frame(input int n);
        cs_n = 1'h0;
        repeat (6) @(negedge sys_clk);
        for (int k = 1; k <= n; k++)
        begin
            conversion_shift_clock = 1'h1;
            cap_d[k] = sdo_oe ? sdo_out : ~cap_d[k-1];
            cap_e[k] = sdo_oe;
            repeat (6) @(negedge sys_clk);
            conversion_shift_clock = 1'h0;
            repeat (6) @(negedge sys_clk);
        end
        cs_n = 1'h1;
        repeat (12) @(negedge sys_clk);
    endtask
endmodule // sadc_host_model
`default_nettype wire

// [verif/sadc_readout_sva.sv]
// Purpose: port checks for the serial readout sequencer
// Assumes: host clock phases last six system clocks, select high at least twelve
// Notes: bound to every sadc_readout instance
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defines.vh"
// ==========
// port checker
module sadc_readout_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    input wire logic cs_n,
    input wire logic conversion_shift_clock,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // stream and status
    input wire logic ain_valid,
    input wire logic ain_ready,
    input wire logic [`SADC_IN_W-1:0] ain_data,
    input wire logic sample_active,
    input wire logic analog_pd,
    input wire logic digital_pd,
    input wire logic result_underrun
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic oe_seen_ff;
    // raw pin clears it; pin phases outlast the sync delay
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            oe_seen_ff <= 1'h0;
        else if (cs_n)
            oe_seen_ff <= 1'h0;
        else if ($rose(sdo_oe))
            oe_seen_ff <= 1'h1;
    end
    sequence s_sampling;
        sample_active [*8] ##[1:40] !sample_active;
    endsequence
    sequence s_null_start;
        $fell(sample_active) && !sdo_out;
    endsequence
    a_sample_len: assert property (
        $rose(sample_active) |-> s_sampling) else $error("sample length");
    a_null_bit: assert property (
        $rose(sdo_oe) |-> s_null_start) else $error("null bit");
    a_sdo_on_fall: assert property ($changed(sdo_out) && sdo_oe
        |-> !conversion_shift_clock && $past(conversion_shift_clock, 5))
        else $error("data changed off falling edge");
    a_hiz_cs_high: assert property (
        cs_n [*5] |-> !sdo_oe) else $error("driving while deselected");
    a_pd_cs_high: assert property (
        cs_n [*5] |-> analog_pd && digital_pd) else $error("not down");
    a_pd_at_end: assert property (
        $fell(sdo_oe) |-> analog_pd) else $error("no power down at end");
    a_one_frame: assert property (
        $rose(sdo_oe) |-> !oe_seen_ff) else $error("second frame");
    a_underrun_hold: assert property (
        $changed(result_underrun) |-> $rose(sdo_oe))
        else $error("capture outside hold");
endmodule // sadc_readout_chk
bind sadc_readout sadc_readout_chk u_sadc_readout_chk (
    .sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
    .conversion_shift_clock(conversion_shift_clock),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ain_valid(ain_valid),
    .ain_ready(ain_ready), .ain_data(ain_data),
    .sample_active(sample_active), .analog_pd(analog_pd),
    .digital_pd(digital_pd), .result_underrun(result_underrun));
`default_nettype wire

// [verif/sadc_readout_test.sv]
// Purpose: self-checking bench of the serial readout sequencer
// Assumes: inputs change on falling system clock edges
// Notes: results compared bit by bit as the host captured them
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defines.vh"
`define HM u_sadc_host_model
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
// ==========
// bench top
module sadc_readout_test;
    logic sys_clk;
    logic resetn;
    logic ain_valid;
    logic [`SADC_IN_W-1:0] ain_data;
    wire logic cs_n, csk, sdo_out, sdo_oe, ain_ready;
    wire logic sample_active, analog_pd, digital_pd, result_underrun;
    int mismatches;
    int cmp_count;
    sadc_readout u_sadc_readout (.sys_clk(sys_clk), .resetn(resetn),
        .cs_n(cs_n), .conversion_shift_clock(csk), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .ain_valid(ain_valid), .ain_ready(ain_ready),
        .ain_data(ain_data), .sample_active(sample_active),
        .analog_pd(analog_pd), .digital_pd(digital_pd),
        .result_underrun(result_underrun));
    sadc_host_model u_sadc_host_model (.sys_clk(sys_clk),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .cs_n(cs_n),
        .conversion_shift_clock(csk));
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic push(input logic [23:0] w);
        int t;
        t = 0;
        @(negedge sys_clk);
        ain_valid = 1'h1;
        ain_data = w;
        while (ain_ready !== 1'h1)
        begin
            if (++t > 50)
            begin
                mismatches++;
                $display("[ERR] %0t input word not taken", $time);
                end_sim();
            end
            @(negedge sys_clk);
        end
        @(negedge sys_clk);
        ain_valid = 1'h0;
    endtask
    task automatic chk_frame(input logic [11:0] x);
        `HM.frame(28);
        `CHK({`HM.cap_e[2], `HM.cap_e[3], `HM.cap_d[3]}, 3'h2)
        for (int i = 0; i < 12; i++)
            `CHK({`HM.cap_e[4+i], `HM.cap_d[4+i]}, {1'h1, x[11-i]})
        for (int i = 0; i < 11; i++)
            `CHK({`HM.cap_e[16+i], `HM.cap_d[16+i]}, {1'h1, x[1+i]})
        `CHK({`HM.cap_e[27], `HM.cap_e[28]}, 2'h0)
    endtask
    // fills the buffer to refusal, then drains it one word per frame
    task automatic t_codes();
        logic [23:0] w [0:4] = '{24'hFFF000, 24'h900100, 24'h7FF000,
            24'h123123, 24'h100200};
        logic [11:0] x [0:15] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000,
            12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
            12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
        for (int i = 0; i < 16; i++)
        begin
            if (i > 4)
                x[i] = {i[3:0], 8'hA4};
            push(i < 5 ? w[i] : {i[3:0], 8'hA5, 12'h001});
        end
        @(negedge sys_clk);
        `CHK(ain_ready, 1'h0)
        for (int i = 0; i < 16; i++)
        begin
            chk_frame(x[i]);
            `CHK(result_underrun, 1'h0)
        end
        `CHK(ain_ready, 1'h1)
    endtask
    // short cycle after eight bits, then an empty-buffer frame
    task automatic t_abort();
        logic [11:0] x = 12'hABC;
        push(24'hABC000);
        `HM.frame(11);
        for (int i = 0; i < 8; i++)
            `CHK({`HM.cap_e[4+i], `HM.cap_d[4+i]}, {1'h1, x[11-i]})
        `CHK({sdo_oe, analog_pd, digital_pd}, 3'h3)
        chk_frame(12'h000);
        `CHK(result_underrun, 1'h1)
    endtask
    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        resetn = 1'h0;
        ain_valid = 1'h0;
        ain_data = 24'h000000;
        mismatches = 0;
        cmp_count = 0;
        repeat (16) @(negedge sys_clk);
        resetn = 1'h1;
        t_codes();
        t_abort();
        end_sim();
    end
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        $display("[ERR] %0t run timed out", $time);
        end_sim();
    end
endmodule // sadc_readout_test
`default_nettype wire
